/* config_load_port_map.vh */
// Constants for the configuration load port: mode codes, counts and reset values.
`ifndef CONFIG_LOAD_PORT_MAP_VH
`define CONFIG_LOAD_PORT_MAP_VH

// Mode-select pin codes, M2..M0 order.
`define MODE_MASTER_SERIAL 3'h0
`define MODE_SLAVE_SERIAL 3'h7
`define MODE_MASTER_PARALLEL 3'h6
`define MODE_PERIPHERAL 3'h5
`define MODE_EXPRESS 3'h2

// First byte of every bitstream; anything else is a data error.
`define CFG_PREAMBLE 8'hff

// Loader states.
`define ST_WAIT 2'h0
`define ST_LOAD 2'h1
`define ST_DONE 2'h2
`define ST_ERROR 2'h3

// Read-strobe status word: ready bit sits on top, the other seven lines High.
`define STATUS_LOW_BITS 7'h7f
`define BYTE_MSB 7

// Master clock divider: half period of the generated config clock in cycles.
`define CONFIG_CLOCK_HALF_DEFAULT 8'h04
`define CONFIG_CLOCK_HALF_ONE 8'h01

// Reset values and increments.
`define ZERO8 8'h00
`define ZERO22 22'h000000
`define ONE22 22'h000001
`define ONE16 16'h0001
`define ZERO16 16'h0000
`define BITS_PER_BYTE 3'h7
`define ZERO3 3'h0
`define ONE3 3'h1

`endif

/* pin_sync.v */
// Two-flop synchroniser bank for inputs that arrive from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input wire clock_i,
    input wire rstn_i,
    // Asynchronous levels in, synchronised levels out.
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;

    // The first stage feeds only the second, so a metastable value never fans out.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // pin_sync

`default_nettype wire

/* config_load_port.v */
// Configuration data entry port: peripheral, serial, master parallel and express loading.
//
// What this block does
// - Selected only while select_low_n low, select_high_enable high.
// - Selected write strobe low captures the data byte.
// - Selected read strobe drives ready status, others high.
// - Write and read together: write wins.
// - Express mode accepts data only while enabled upstream.
// - Master parallel drives 18-bit PROM address.
// - Wide variant adds four upper address outputs.
// - Parallel and peripheral modes take eight-bit bytes.
// - Serial input sampled on config clock rising edge.
// - Serial input pin is bit zero in parallel modes.
// - Serial output forwards data except in express.
// - Forwarded bit changes on falling edge, 1.5 periods later.
// - Express serial output carries downstream enable status.
// - After configuration all pins release to user.
// - Sample mode pins after init goes high.
// - Pull init low on configuration data error.
// - Hold high_during_config high until user pins active.
// - PROM read clock rises before each address change.
`timescale 1ns/100ps
`default_nettype none
`include "config_load_port_map.vh"

module config_load_port #(
    parameter ADDR_WIDTH = 18,
    parameter UPPER_WIDTH = 4,
    parameter WIDE_ADDRESS = 1,
    parameter [15:0] CONFIG_BYTES = 16'h0040,
    parameter [7:0] CONFIG_CLOCK_HALF = `CONFIG_CLOCK_HALF_DEFAULT
) (
    // Clock and reset.
    input wire clock_i,
    input wire rstn_i,
    // Mode select and open-drain init.
    input wire [2:0] mode_select_pins_i,
    input wire init_n_i,
    output reg init_n_o,
    output reg init_n_oe_n_o,
    // Configuration clock: sampled in slave modes, driven in master modes.
    input wire config_clock_i,
    output reg config_clock_o,
    output reg config_clock_oe_n_o,
    // Serial data in and out.
    input wire serial_data_i,
    output reg serial_data_o,
    output reg serial_data_oe_n_o,
    // Peripheral selects and strobes.
    input wire select_low_n_i,
    input wire select_high_enable_i,
    input wire write_strobe_n_i,
    input wire read_strobe_n_i,
    // Parallel data bus.
    input wire [7:0] config_byte_bus_i,
    output reg [7:0] config_byte_bus_o,
    output reg config_byte_bus_oe_n_o,
    // PROM addressing.
    output reg [ADDR_WIDTH-1:0] prom_address_out_o,
    output reg [UPPER_WIDTH-1:0] prom_address_upper_o,
    output reg address_oe_n_o,
    output reg prom_read_clock_o,
    // Progress outputs.
    output reg high_during_config_o,
    output reg user_io_active_o,
    // Byte handed to the configuration memory; buffer_ready_i accepts it.
    output reg [7:0] config_byte_o,
    output reg config_byte_valid_o,
    input wire buffer_ready_i
);

    localparam SYNC_W = 18;
    localparam AW = ADDR_WIDTH + UPPER_WIDTH;

    wire [SYNC_W-1:0] sync_w;
    wire [2:0] mode_s;
    wire init_s, config_clock_s, din_s, cs0_s, cs1_s, ws_s, rs_s;
    wire [7:0] bus_s;

    // Every pin input crosses two flops before use.
    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i({mode_select_pins_i, init_n_i, config_clock_i, serial_data_i,
                  select_low_n_i, select_high_enable_i, write_strobe_n_i,
                  read_strobe_n_i, config_byte_bus_i}),
        .sync_o(sync_w)
    );
    assign mode_s = sync_w[17:15];
    assign init_s = sync_w[14];
    assign config_clock_s = sync_w[13];
    assign din_s = sync_w[12];
    assign cs0_s = sync_w[11];
    assign cs1_s = sync_w[10];
    assign ws_s = sync_w[9];
    assign rs_s = sync_w[8];
    assign bus_s = sync_w[7:0];

    reg [1:0] state_q;
    reg [2:0] mode_q;
    reg config_clock_prev_q;
    reg [7:0] div_q;
    reg gen_clk_q;
    reg [7:0] shift_q;
    reg [2:0] bit_q;
    reg [15:0] count_q;
    reg first_q;
    reg fwd0_q, fwd1_q;
    reg ws_prev_q;
    reg busy_q;
    reg [AW-1:0] addr_q;
    reg par_phase_q;

    wire loading = (state_q == `ST_LOAD);
    wire is_master = (mode_q == `MODE_MASTER_SERIAL) || (mode_q == `MODE_MASTER_PARALLEL);
    wire is_serial = (mode_q == `MODE_MASTER_SERIAL) || (mode_q == `MODE_SLAVE_SERIAL);
    wire is_express = (mode_q == `MODE_EXPRESS);
    wire is_periph = (mode_q == `MODE_PERIPHERAL);
    wire is_mpar = (mode_q == `MODE_MASTER_PARALLEL);

    // Master modes time themselves on the divided clock, slave modes on the pin.
    wire div_tick = (div_q == CONFIG_CLOCK_HALF - `CONFIG_CLOCK_HALF_ONE);
    wire clk_level = is_master ? gen_clk_q : config_clock_s;
    wire config_clock_rise = loading && clk_level && !config_clock_prev_q;
    wire config_clock_fall = loading && !clk_level && config_clock_prev_q;

    wire selected = !cs0_s && cs1_s;
    wire ws_fall = selected && !ws_s && ws_prev_q;
    // Bit zero of every parallel byte comes from the serial input pin.
    wire [7:0] par_byte = {bus_s[7:1], din_s};

    // One byte may be taken per event; serial bytes complete on the eighth bit.
    reg take_byte;
    reg [7:0] new_byte;
    always @* begin
        take_byte = 1'b0;
        new_byte = par_byte;
        if (loading) begin
            if (is_serial && config_clock_rise && bit_q == `BITS_PER_BYTE) begin
                take_byte = 1'b1;
                new_byte = {shift_q[6:0], din_s};
            end else if (is_periph && ws_fall && !busy_q) begin
                take_byte = 1'b1;
            end else if (is_express && config_clock_rise && cs1_s) begin
                take_byte = 1'b1;
            end else if (is_mpar && div_tick && par_phase_q && !gen_clk_q) begin
                // Taken as the read clock falls: the synced PROM byte has settled by then.
                take_byte = 1'b1;
            end
        end
    end

    wire last_byte = take_byte && (count_q == CONFIG_BYTES - `ONE16);
    wire bad_first = take_byte && first_q && (new_byte != `CFG_PREAMBLE);

    // Loader sequencing: wait for init release, load, then hand pins to the user.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= `ST_WAIT;
            mode_q <= `MODE_SLAVE_SERIAL;
            count_q <= `ZERO16;
            first_q <= 1'b1;
        end else begin
            case (state_q)
                `ST_WAIT: begin
                    if (init_s) begin
                        mode_q <= mode_s;
                        state_q <= `ST_LOAD;
                    end
                end
                `ST_LOAD: begin
                    if (bad_first) begin
                        state_q <= `ST_ERROR;
                    end else if (last_byte) begin
                        state_q <= `ST_DONE;
                    end else if (take_byte) begin
                        count_q <= count_q + `ONE16;
                        first_q <= 1'b0;
                    end
                end
                `ST_DONE: state_q <= `ST_DONE;
                `ST_ERROR: state_q <= `ST_ERROR;
                default: state_q <= `ST_WAIT;
            endcase
        end
    end

    // Master clock divider; a free-running half-period counter is simplest to reason about.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= `ZERO8;
            gen_clk_q <= 1'b0;
            config_clock_prev_q <= 1'b0;
        end else begin
            config_clock_prev_q <= clk_level;
            if (div_tick) begin
                div_q <= `ZERO8;
                gen_clk_q <= loading && is_master && !gen_clk_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // Serial shift and the two-stage forward pipe for the daisy chain.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_q <= `ZERO8;
            bit_q <= `ZERO3;
            fwd0_q <= 1'b1;
            fwd1_q <= 1'b1;
        end else if (config_clock_rise) begin
            shift_q <= {shift_q[6:0], din_s};
            bit_q <= bit_q + `ONE3;
            fwd0_q <= din_s;
            fwd1_q <= fwd0_q;
        end
    end

    // Peripheral busy flag: set by a captured write, cleared once the byte is accepted.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ws_prev_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            ws_prev_q <= ws_s;
            if (is_periph && take_byte) begin
                busy_q <= 1'b1;
            end else if (config_byte_valid_o && buffer_ready_i) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Byte hand-off register; the set wins over the accept in the same cycle.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            config_byte_o <= `ZERO8;
            config_byte_valid_o <= 1'b0;
        end else if (take_byte && !bad_first) begin
            config_byte_o <= new_byte;
            config_byte_valid_o <= 1'b1;
        end else if (buffer_ready_i) begin
            config_byte_valid_o <= 1'b0;
        end
    end

    // PROM addressing: read clock rises, then the address steps two ticks later, as the generated clock rises again.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_q <= `ZERO22;
            par_phase_q <= 1'b0;
            prom_read_clock_o <= 1'b0;
        end else if (loading && is_mpar && div_tick && !gen_clk_q) begin
            if (!par_phase_q) begin
                prom_read_clock_o <= 1'b1;
                par_phase_q <= 1'b1;
            end else begin
                prom_read_clock_o <= 1'b0;
                addr_q <= addr_q + `ONE22;
                par_phase_q <= 1'b0;
            end
        end
    end

    // Pin drivers; every oe_n goes high once configuration ends; on failure all but init_n_oe_n_o, which goes low.
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            init_n_o <= 1'b0;
            init_n_oe_n_o <= 1'b1;
            config_clock_o <= 1'b0;
            config_clock_oe_n_o <= 1'b1;
            serial_data_o <= 1'b1;
            serial_data_oe_n_o <= 1'b1;
            config_byte_bus_o <= `ZERO8;
            config_byte_bus_oe_n_o <= 1'b1;
            prom_address_out_o <= {ADDR_WIDTH{1'b0}};
            prom_address_upper_o <= {UPPER_WIDTH{1'b0}};
            address_oe_n_o <= 1'b1;
            high_during_config_o <= 1'b1;
            user_io_active_o <= 1'b0;
        end else begin
            init_n_o <= 1'b0;
            init_n_oe_n_o <= !(state_q == `ST_ERROR);
            config_clock_o <= gen_clk_q;
            config_clock_oe_n_o <= !(loading && is_master);
            serial_data_oe_n_o <= !loading;
            if (is_express) begin
                serial_data_o <= (count_q == CONFIG_BYTES - `ONE16);
            end else if (config_clock_fall) begin
                serial_data_o <= fwd1_q;
            end
            // Read status only when the write strobe is idle, so a write wins.
            if (loading && is_periph && selected && !rs_s && ws_s) begin
                config_byte_bus_o <= {!busy_q, `STATUS_LOW_BITS};
                config_byte_bus_oe_n_o <= 1'b0;
            end else begin
                config_byte_bus_oe_n_o <= 1'b1;
            end
            prom_address_out_o <= addr_q[ADDR_WIDTH-1:0];
            prom_address_upper_o <= WIDE_ADDRESS ? addr_q[AW-1:ADDR_WIDTH]
                                                 : {UPPER_WIDTH{1'b0}};
            address_oe_n_o <= !(loading && is_mpar);
            high_during_config_o <= !(state_q == `ST_DONE);
            user_io_active_o <= (state_q == `ST_DONE);
        end
    end

endmodule // config_load_port

`default_nettype wire

/* config_load_port_assertions.sv */
// Port-level checker for the configuration load port, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
`include "config_load_port_map.vh"
module config_load_port_assertions #(
    parameter ADDR_WIDTH = 18
) (
    // Clock, reset and the pins that cause behaviour.
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [2:0] mode_select_pins_i,
    input wire logic init_n_i,
    input wire logic select_low_n_i,
    input wire logic select_high_enable_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic buffer_ready_i,
    // Outputs under watch.
    input wire logic [7:0] config_byte_bus_o,
    input wire logic config_byte_bus_oe_n_o,
    input wire logic init_n_oe_n_o,
    input wire logic serial_data_oe_n_o,
    input wire logic config_clock_oe_n_o,
    input wire logic address_oe_n_o,
    input wire logic [ADDR_WIDTH-1:0] prom_address_out_o,
    input wire logic prom_read_clock_o,
    input wire logic high_during_config_o,
    input wire logic user_io_active_o,
    input wire logic config_byte_valid_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // A selected, write-free read; the pins cross two flops, so it must persist.
    wire rd_on = !select_low_n_i && select_high_enable_i && !read_strobe_n_i && write_strobe_n_i;
    sequence s_read_held;
        (rd_on && init_n_i && high_during_config_o && mode_select_pins_i == `MODE_PERIPHERAL) [*5];
    endsequence
    property p_read_drive;
        s_read_held |-> !config_byte_bus_oe_n_o;
    endproperty
    property p_bus_cause;
        $fell(config_byte_bus_oe_n_o) |->
            $past(!select_low_n_i && select_high_enable_i && !read_strobe_n_i, 3);
    endproperty
    property p_status_bits;
        !config_byte_bus_oe_n_o |-> config_byte_bus_o[6:0] == `STATUS_LOW_BITS;
    endproperty
    property p_progress;
        high_during_config_o != user_io_active_o;
    endproperty
    property p_release;
        user_io_active_o |-> &{config_byte_bus_oe_n_o, init_n_oe_n_o, serial_data_oe_n_o,
            config_clock_oe_n_o, address_oe_n_o};
    endproperty
    property p_error;
        !init_n_oe_n_o |-> high_during_config_o;
    endproperty
    property p_addr_step;
        $changed(prom_address_out_o) |-> $past(prom_read_clock_o, 2);
    endproperty
    property p_addr_mode;
        !address_oe_n_o |-> mode_select_pins_i == `MODE_MASTER_PARALLEL;
    endproperty
    property p_valid_hold;
        config_byte_valid_o && !buffer_ready_i |=> config_byte_valid_o;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("status not driven");
    a_bus_cause: assert property (p_bus_cause) else $error("bus driven unselected");
    a_status_bits: assert property (p_status_bits) else $error("status low bits");
    a_progress: assert property (p_progress) else $error("progress flags");
    a_release: assert property (p_release) else $error("pins not released");
    a_error: assert property (p_error) else $error("error flag after done");
    a_addr_step: assert property (p_addr_step) else $error("address step");
    a_addr_mode: assert property (p_addr_mode) else $error("address mode");
    a_valid_hold: assert property (p_valid_hold) else $error("byte dropped");
endmodule // config_load_port_assertions
bind config_load_port config_load_port_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .mode_select_pins_i(mode_select_pins_i),
    .init_n_i(init_n_i),
    .select_low_n_i(select_low_n_i),
    .select_high_enable_i(select_high_enable_i),
    .write_strobe_n_i(write_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i),
    .buffer_ready_i(buffer_ready_i),
    .config_byte_bus_o(config_byte_bus_o),
    .config_byte_bus_oe_n_o(config_byte_bus_oe_n_o),
    .init_n_oe_n_o(init_n_oe_n_o),
    .serial_data_oe_n_o(serial_data_oe_n_o),
    .config_clock_oe_n_o(config_clock_oe_n_o),
    .address_oe_n_o(address_oe_n_o),
    .prom_address_out_o(prom_address_out_o),
    .prom_read_clock_o(prom_read_clock_o),
    .high_during_config_o(high_during_config_o),
    .user_io_active_o(user_io_active_o),
    .config_byte_valid_o(config_byte_valid_o)
);
`default_nettype wire

/* config_source_model.sv */
// Far-side model: serial bit source, parallel PROM and host byte lines.
`timescale 1ns/100ps
`default_nettype none
module config_source_model (
    // Design pins watched by the model.
    input wire logic [17:0] prom_address_i,
    input wire logic address_oe_n_i,
    input wire logic serial_fwd_i,
    input wire logic serial_oe_n_i,
    // Pins driven towards the design.
    output logic config_clock_o,
    output logic serial_data_o,
    output logic [7:0] config_byte_bus_o
);
    logic [7:0] host_q = 8'h00;
    logic ser_on = 1'b0;
    logic bit_q = 1'b0;
    logic [1:0] hist = 2'h0;
    int nbits = 0;
    int fwd_err = 0;
    // PROM holds the preamble at address zero and a pattern elsewhere.
    assign config_byte_bus_o = !address_oe_n_i ?
        ((prom_address_i == 18'h0) ? 8'hff : prom_address_i[7:0] ^ 8'h5a) : host_q;
    assign serial_data_o = ser_on ? bit_q : config_byte_bus_o[0];
    initial config_clock_o = 1'b0;
    // MSB first; the clock stands low between frames, offset from the system clock.
    task automatic send(input logic [7:0] b);
        #7;
        for (int i = 7; i >= 0; i--) begin
            bit_q = b[i];
            #100 config_clock_o = 1'b1;
            #90;
            if (!serial_oe_n_i && nbits >= 2 && serial_fwd_i !== hist[1]) fwd_err++;
            hist = {hist[0], b[i]};
            nbits++;
            #10 config_clock_o = 1'b0;
        end
    endtask
endmodule // config_source_model
`default_nettype wire

/* test_config_load_port.sv */
// Self-checking bench for the configuration load port.
`timescale 1ns/100ps
`default_nettype none
`include "config_load_port_map.vh"
module test_config_load_port;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] mode = 3'h0;
    logic init_n = 1'b0, sel_n = 1'b1, sel_h = 1'b0, ws_n = 1'b1, rs_n = 1'b1, ready = 1'b1;
    wire config_clock, sdi, init_oe_n, sdo, sdo_oe_n, bus_oe_n, config_clock_oe_n, addr_oe_n, rdclk;
    wire high_during_config, user_on, valid;
    wire [7:0] bus_in, bus_out, cbyte;
    wire [17:0] addr;
    wire [3:0] addr_hi;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] exp_q[$];
    config_load_port #(.CONFIG_BYTES(16'h0004)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .mode_select_pins_i(mode), .init_n_i(init_n), .init_n_o(), .init_n_oe_n_o(init_oe_n),
        .config_clock_i(config_clock), .config_clock_o(), .config_clock_oe_n_o(config_clock_oe_n),
        .serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_n_o(sdo_oe_n),
        .select_low_n_i(sel_n), .select_high_enable_i(sel_h), .write_strobe_n_i(ws_n),
        .read_strobe_n_i(rs_n), .config_byte_bus_i(bus_in), .config_byte_bus_o(bus_out),
        .config_byte_bus_oe_n_o(bus_oe_n), .prom_address_out_o(addr),
        .prom_address_upper_o(addr_hi),
        .address_oe_n_o(addr_oe_n), .prom_read_clock_o(rdclk), .high_during_config_o(high_during_config),
        .user_io_active_o(user_on), .config_byte_o(cbyte), .config_byte_valid_o(valid),
        .buffer_ready_i(ready));
    config_source_model src_u (.prom_address_i(addr), .address_oe_n_i(addr_oe_n),
        .serial_fwd_i(sdo), .serial_oe_n_i(sdo_oe_n), .config_clock_o(config_clock),
        .serial_data_o(sdi), .config_byte_bus_o(bus_in));
    // The clock, and a watchdog sized well past the longest run.
    initial forever #12.5 clock_i = ~clock_i;
    initial begin
        #400000;
        miscompares++;
        close_out();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Every byte handed on must be the next one expected; a stray byte is a mismatch.
    always @(posedge clock_i) begin
        if (rstn_i && valid && ready) begin
            if (exp_q.size() > 0) check(cbyte, exp_q.pop_front());
            else check({7'h0, valid}, 8'h00);
        end
    end
    // Reset, then pick the mode and release init so the mode is sampled.
    task automatic start(input logic [2:0] m);
        rstn_i <= 1'b0;
        init_n <= 1'b0;
        mode <= m;
        ready <= 1'b1;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        init_n <= 1'b1;
        repeat (8) @(posedge clock_i);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 4000 && high_during_config !== 1'b0; i++) @(posedge clock_i);
        check({7'h0, user_on}, 8'h01);
        check(8'(exp_q.size()), 8'h00);
    endtask
    // Peripheral write, optionally with the read strobe low as well.
    task automatic write(input logic [7:0] b, input logic selh, input logic both);
        src_u.host_q <= b;
        sel_n <= 1'b0;
        sel_h <= selh;
        rs_n <= !both;
        repeat (2) @(posedge clock_i);
        ws_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        ws_n <= 1'b1;
        rs_n <= 1'b1;
        repeat (6) @(posedge clock_i);
        sel_n <= 1'b1;
        @(posedge clock_i);
    endtask
    task automatic read_status(input logic rdy);
        sel_n <= 1'b0;
        sel_h <= 1'b1;
        rs_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        check(bus_out, {rdy, `STATUS_LOW_BITS});
        check({7'h0, bus_oe_n}, 8'h00);
        rs_n <= 1'b1;
        sel_n <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask
    // Main sequence: reset values, serial, error, master parallel, peripheral, express.
    initial begin
        logic [7:0] b;
        void'($urandom(89));
        repeat (12) @(posedge clock_i);
        check({high_during_config, user_on, valid, bus_oe_n, addr_oe_n, sdo_oe_n, init_oe_n, config_clock_oe_n},
            8'h9f);
        src_u.ser_on <= 1'b1;
        start(`MODE_SLAVE_SERIAL);
        src_u.nbits = 0;
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? `CFG_PREAMBLE : 8'($urandom);
            exp_q.push_back(b);
            src_u.send(b);
        end
        wait_done();
        check(8'(src_u.fwd_err), 8'h00);
        start(`MODE_SLAVE_SERIAL);
        ready <= 1'b0;
        src_u.send(8'h3c);
        repeat (10) @(posedge clock_i);
        check({6'h0, init_oe_n, high_during_config}, 8'h01);
        src_u.ser_on <= 1'b0;
        for (int k = 0; k < 4; k++) exp_q.push_back((k == 0) ? 8'hff : 8'(k) ^ 8'h5a);
        start(`MODE_MASTER_PARALLEL);
        wait_done();
        check(addr[7:0], 8'h04);
        check({4'h0, addr_hi}, 8'h00);
        start(`MODE_PERIPHERAL);
        ready <= 1'b0;
        exp_q.push_back(8'hff);
        write(8'h11, 1'b0, 1'b0);
        write(8'hff, 1'b1, 1'b0);
        read_status(1'b0);
        ready <= 1'b1;
        repeat (4) @(posedge clock_i);
        read_status(1'b1);
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            write(b, 1'b1, k == 0);
        end
        wait_done();
        // Express: no byte while the upstream enable is low, then four with it high.
        start(`MODE_EXPRESS);
        src_u.host_q <= `CFG_PREAMBLE;
        sel_h <= 1'b0;
        src_u.send(8'h00);
        @(posedge clock_i);
        check({7'h0, sdo}, 8'h00);
        sel_h <= 1'b1;
        repeat (4) exp_q.push_back(`CFG_PREAMBLE);
        src_u.send(8'h00);
        wait_done();
        check({7'h0, sdo}, 8'h01);
        close_out();
    end
endmodule // test_config_load_port
`default_nettype wire
